/* src/gpm_defs.svh */
// Register offsets, field positions, reset values and timing counts of the gesture pulse and mode control block.
`ifndef GPM_DEFS_SVH
`define GPM_DEFS_SVH
`define GPM_DEV_ADDR        7'h39
`define GPM_OFS_PULSE_SETUP 8'hA6
`define GPM_OFS_AXIS_SELECT 8'hAA
`define GPM_OFS_CONTROL     8'hAB
`define GPM_OFS_FILL_COUNT  8'hAE
`define GPM_OFS_STATUS      8'hAF
`define GPM_PULSE_SETUP_RST 8'h40
`define GPM_AXIS_SELECT_RST 8'h00
`define GPM_CONTROL_RST     8'h00
`define GPM_WIDTH_MSB       7
`define GPM_WIDTH_LSB       6
`define GPM_COUNT_MSB       5
`define GPM_COUNT_LSB       0
`define GPM_AXIS_MSB        1
`define GPM_AXIS_LSB        0
`define GPM_CTL_FLUSH       2
`define GPM_CTL_UNMASK      1
`define GPM_CTL_ACTIVE      0
`define GPM_CLK_MHZ         100
`define GPM_PULSE_BASE_US   4
`define GPM_PULSE_BASE_CYC  (`GPM_PULSE_BASE_US * `GPM_CLK_MHZ)
`define GPM_GAP_CYC         16'h0190
`endif

/* src/gpm_gesture_ctrl.sv */
// Gesture pulse sequencer, axis selection and mode control with its serial register access.
`timescale 1ns/1ns
`include "gpm_defs.svh"

module gpm_gesture_ctrl (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       sclPin,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe_n,
    output logic            ledDrivePin_n,
    output logic            sampleUpDown,
    output logic            sampleLeftRight,
    output logic            intOut,
    output logic            intOe_n,
    input  wire logic       entryThresholdHit,
    input  wire logic       exitThresholdHit,
    input  wire logic       datasetStored,
    input  wire logic       datasetRead,
    input  wire logic [7:0] queueFifoThreshold
);
    logic [7:0] pulseSetup_reg;
    logic [1:0] axisSelect_reg;
    logic       irqUnmask_reg;
    logic       gestureActive_reg;
    logic       exitPending_reg;
    logic       dataReady_reg;
    logic       overflow_reg;
    logic       irqFlag_reg;
    logic [7:0] fillCount_reg;
    logic [7:0] regAddr;
    logic [7:0] wrData;
    logic       wrStrobe;
    logic [7:0] rdData;
    logic       flushStrobe;
    logic       stopRequest;
    logic       convBusy;
    logic [5:0] pulsesLeft_reg;
    logic [15:0] timer_reg;
    logic       halfPhase_reg;
    gpm_pkg::gpm_pulse_state_t pstate_reg;

    // Cycles of Phase_a-time for a width code: base 4 us doubled per code step.
    function automatic logic [15:0] pulseCycles(input logic [1:0] code);
        pulseCycles = 16'(`GPM_PULSE_BASE_CYC) << code;
    endfunction

    gpm_serial_slave u_slave (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .sclPin   (sclPin),
        .sdaIn    (sdaIn),
        .sdaOut   (sdaOut),
        .sdaOe_n  (sdaOe_n),
        .regAddr  (regAddr),
        .wrData   (wrData),
        .wrStrobe (wrStrobe),
        .rdData   (rdData),
        .rdStrobe ()
    );

    assign flushStrobe = wrStrobe && regAddr == `GPM_OFS_CONTROL && wrData[`GPM_CTL_FLUSH];
    assign stopRequest = wrStrobe && regAddr == `GPM_OFS_CONTROL && !wrData[`GPM_CTL_ACTIVE];
    assign convBusy    = pstate_reg != gpm_pkg::GPM_PS_IDLE;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pulseSetup_reg <= `GPM_PULSE_SETUP_RST;
            axisSelect_reg <= 2'(`GPM_AXIS_SELECT_RST);
            irqUnmask_reg  <= 1'b0;
        end else if (wrStrobe) begin
            if (regAddr == `GPM_OFS_PULSE_SETUP) begin
                pulseSetup_reg <= wrData;
            end
            if (regAddr == `GPM_OFS_AXIS_SELECT) begin
                axisSelect_reg <= wrData[`GPM_AXIS_MSB:`GPM_AXIS_LSB];
            end
            if (regAddr == `GPM_OFS_CONTROL) begin
                irqUnmask_reg <= wrData[`GPM_CTL_UNMASK];
            end
        end
    end

    // Mode state; a stop request waits for the running gesture cycle to return the sequencer to idle.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            gestureActive_reg <= 1'b0;
            exitPending_reg   <= 1'b0;
        end else if (wrStrobe && regAddr == `GPM_OFS_CONTROL && wrData[`GPM_CTL_ACTIVE]) begin
            gestureActive_reg <= 1'b1;
            exitPending_reg   <= 1'b0;
        end else if ((stopRequest || exitPending_reg || exitThresholdHit) && gestureActive_reg) begin
            if (!convBusy) begin
                gestureActive_reg <= 1'b0;
                exitPending_reg   <= 1'b0;
            end else begin
                exitPending_reg <= 1'b1;
            end
        end else if (entryThresholdHit) begin
            gestureActive_reg <= 1'b1;
        end
    end

    // Pulse sequencer: on, gap, repeat, then a conversion slot before the next cycle.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pstate_reg     <= gpm_pkg::GPM_PS_IDLE;
            pulsesLeft_reg <= 6'h00;
            timer_reg      <= 16'h0000;
            halfPhase_reg  <= 1'b0;
            ledDrivePin_n  <= 1'b1;
        end else begin
            unique case (pstate_reg)
                gpm_pkg::GPM_PS_IDLE: begin
                    ledDrivePin_n <= 1'b1;
                    if (gestureActive_reg && !exitPending_reg) begin
                        pulsesLeft_reg <= pulseSetup_reg[`GPM_COUNT_MSB:`GPM_COUNT_LSB];
                        timer_reg      <= pulseCycles(pulseSetup_reg[`GPM_WIDTH_MSB:`GPM_WIDTH_LSB]) - 16'h0001;
                        ledDrivePin_n  <= 1'b0;
                        pstate_reg     <= gpm_pkg::GPM_PS_ON;
                    end
                end
                gpm_pkg::GPM_PS_ON: begin
                    if (timer_reg == 16'h0000) begin
                        ledDrivePin_n <= 1'b1;
                        timer_reg     <= `GPM_GAP_CYC - 16'h0001;
                        pstate_reg    <= (pulsesLeft_reg == 6'h00) ? gpm_pkg::GPM_PS_CONV : gpm_pkg::GPM_PS_GAP;
                    end else begin
                        timer_reg <= timer_reg - 16'h0001;
                    end
                end
                gpm_pkg::GPM_PS_GAP: begin
                    if (timer_reg == 16'h0000) begin
                        pulsesLeft_reg <= pulsesLeft_reg - 6'h01;
                        timer_reg      <= pulseCycles(pulseSetup_reg[`GPM_WIDTH_MSB:`GPM_WIDTH_LSB]) - 16'h0001;
                        ledDrivePin_n  <= 1'b0;
                        pstate_reg     <= gpm_pkg::GPM_PS_ON;
                    end else begin
                        timer_reg <= timer_reg - 16'h0001;
                    end
                end
                gpm_pkg::GPM_PS_CONV: begin
                    if (timer_reg == 16'h0000) begin
                        halfPhase_reg <= ~halfPhase_reg;
                        pstate_reg    <= gpm_pkg::GPM_PS_DONE;
                    end else begin
                        timer_reg <= timer_reg - 16'h0001;
                    end
                end
                gpm_pkg::GPM_PS_DONE: begin
                    pstate_reg <= gpm_pkg::GPM_PS_IDLE;
                end
                default: begin
                    pstate_reg <= gpm_pkg::GPM_PS_IDLE;
                end
            endcase
        end
    end

    // single pair doubles rate
    // Both pairs share alternate cycles; one pair alone takes every cycle.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sampleUpDown    <= 1'b0;
            sampleLeftRight <= 1'b0;
        end else begin
            sampleUpDown    <= 1'b0;
            sampleLeftRight <= 1'b0;
            if (pstate_reg == gpm_pkg::GPM_PS_DONE) begin
                unique case (axisSelect_reg)
                    2'h1: sampleUpDown <= 1'b1;
                    2'h2: sampleLeftRight <= 1'b1;
                    default: begin
                        sampleUpDown    <= ~halfPhase_reg;
                        sampleLeftRight <= halfPhase_reg;
                    end
                endcase
            end
        end
    end

    // Queue flags; a flush clears everything, and a store in that same cycle is dropped with the flushed data.
    always_ff @(posedge core_clk) begin
        if (!rst_n || flushStrobe) begin
            fillCount_reg <= 8'h00;
            overflow_reg  <= 1'b0;
            dataReady_reg <= 1'b0;
            irqFlag_reg   <= 1'b0;
        end else begin
            if (datasetStored && fillCount_reg == 8'h20) begin
                overflow_reg <= 1'b1;
            end else if (datasetStored && !datasetRead) begin
                fillCount_reg <= fillCount_reg + 8'h01;
            end else if (datasetRead && !datasetStored && fillCount_reg != 8'h00) begin
                fillCount_reg <= fillCount_reg - 8'h01;
            end
            if (fillCount_reg > queueFifoThreshold) begin
                dataReady_reg <= 1'b1;
                irqFlag_reg   <= 1'b1;
            end else if (!gestureActive_reg && fillCount_reg == 8'h00) begin
                dataReady_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            intOut  <= 1'b1;
            intOe_n <= 1'b1;
        end else begin
            intOut  <= 1'b0;
            intOe_n <= ~(irqUnmask_reg && irqFlag_reg);
        end
    end

    // Read mux; flush reads zero and the mode bit shows live machine state.
    always_comb begin
        unique case (regAddr)
            `GPM_OFS_PULSE_SETUP: rdData = pulseSetup_reg;
            `GPM_OFS_AXIS_SELECT: rdData = {6'h00, axisSelect_reg};
            `GPM_OFS_CONTROL:     rdData = {6'h00, irqUnmask_reg, gestureActive_reg};
            `GPM_OFS_FILL_COUNT:  rdData = fillCount_reg;
            `GPM_OFS_STATUS:      rdData = {6'h00, overflow_reg, dataReady_reg};
            default:              rdData = 8'h00;
        endcase
    end
endmodule

/* src/gpm_pkg.sv */
// Types shared by the gesture pulse and mode control block.
package gpm_pkg;
    typedef enum logic [4:0] {
        GPM_PS_IDLE  = 5'b00001,
        GPM_PS_ON    = 5'b00010,
        GPM_PS_GAP   = 5'b00100,
        GPM_PS_CONV  = 5'b01000,
        GPM_PS_DONE  = 5'b10000
    } gpm_pulse_state_t;
    typedef enum logic [3:0] {
        GPM_BS_IDLE = 4'b0001,
        GPM_BS_ADDR = 4'b0010,
        GPM_BS_DATA = 4'b0100,
        GPM_BS_ACK  = 4'b1000
    } gpm_bus_state_t;
endpackage

/* src/gpm_serial_slave.sv */
// Two-wire serial register slave with synchronised pins, register pointer and byte strobes.
`timescale 1ns/1ns
`include "gpm_defs.svh"
module gpm_serial_slave (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       sclPin,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe_n,
    output logic [7:0]      regAddr,
    output logic [7:0]      wrData,
    output logic            wrStrobe,
    input  wire logic [7:0] rdData,
    output logic            rdStrobe
);
    logic [1:0] sclSync_reg;
    logic [1:0] sdaSync_reg;
    logic       sclLast_reg;
    logic       sdaLast_reg;
    logic [7:0] shift_reg;
    logic [3:0] bitCnt_reg;
    logic       readMode_reg;
    logic       havePtr_reg;
    logic       ackByte_reg;
    logic       addrPhase_reg;
    logic [7:0] txByte_reg;
    gpm_pkg::gpm_bus_state_t state_reg;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;

    // Two flip-flops on each pin before anything reads them.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sclSync_reg <= 2'h3;
            sdaSync_reg <= 2'h3;
            sclLast_reg <= 1'b1;
            sdaLast_reg <= 1'b1;
        end else begin
            sclSync_reg <= {sclSync_reg[0], sclPin};
            sdaSync_reg <= {sdaSync_reg[0], sdaIn};
            sclLast_reg <= sclSync_reg[1];
            sdaLast_reg <= sdaSync_reg[1];
        end
    end

    assign sclRise   = sclSync_reg[1] & ~sclLast_reg;
    assign sclFall   = ~sclSync_reg[1] & sclLast_reg;
    assign startSeen = sclSync_reg[1] & sclLast_reg & sdaLast_reg & ~sdaSync_reg[1];
    assign stopSeen  = sclSync_reg[1] & sclLast_reg & ~sdaLast_reg & sdaSync_reg[1];

    // Byte engine; the pointer auto-increments after each read data byte for page access; written data bytes all go to one address.
    always_ff @(posedge core_clk) begin
        wrStrobe <= 1'b0;
        rdStrobe <= 1'b0;
        if (!rst_n) begin
            state_reg     <= gpm_pkg::GPM_BS_IDLE;
            shift_reg     <= 8'h00;
            bitCnt_reg    <= 4'h0;
            readMode_reg  <= 1'b0;
            havePtr_reg   <= 1'b0;
            ackByte_reg   <= 1'b0;
            addrPhase_reg <= 1'b0;
            txByte_reg    <= 8'h00;
            regAddr       <= 8'h00;
            wrData        <= 8'h00;
            sdaOut        <= 1'b1;
            sdaOe_n       <= 1'b1;
        end else if (startSeen) begin
            state_reg     <= gpm_pkg::GPM_BS_ADDR;
            bitCnt_reg    <= 4'h0;
            havePtr_reg   <= 1'b0;
            addrPhase_reg <= 1'b1;
            sdaOe_n       <= 1'b1;
        end else if (stopSeen) begin
            state_reg <= gpm_pkg::GPM_BS_IDLE;
            sdaOe_n   <= 1'b1;
        end else begin
            unique case (state_reg)
                gpm_pkg::GPM_BS_IDLE: begin
                    sdaOe_n <= 1'b1;
                end
                gpm_pkg::GPM_BS_ADDR, gpm_pkg::GPM_BS_DATA: begin
                    if (sclRise) begin
                        shift_reg  <= {shift_reg[6:0], sdaSync_reg[1]};
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                    end
                    // Open-drain output: a one releases the wire so that only the pull-up drives it high.
                    if (sclFall && readMode_reg && !addrPhase_reg) begin
                        sdaOut     <= 1'b0;
                        sdaOe_n    <= txByte_reg[7];
                        txByte_reg <= {txByte_reg[6:0], 1'b0};
                    end
                    if (sclFall && bitCnt_reg == 4'h8) begin
                        bitCnt_reg <= 4'h0;
                        ackByte_reg <= 1'b0;
                        state_reg   <= gpm_pkg::GPM_BS_ACK;
                        if (addrPhase_reg) begin
                            readMode_reg  <= shift_reg[0];
                            addrPhase_reg <= 1'b0;
                            ackByte_reg   <= (shift_reg[7:1] == `GPM_DEV_ADDR);
                            sdaOut        <= 1'b0;
                            sdaOe_n       <= ~(shift_reg[7:1] == `GPM_DEV_ADDR);
                        end else if (readMode_reg) begin
                            sdaOe_n <= 1'b1;
                            regAddr <= regAddr + 8'h01;
                        end else begin
                            ackByte_reg <= 1'b1;
                            sdaOut      <= 1'b0;
                            sdaOe_n     <= 1'b0;
                            if (!havePtr_reg) begin
                                regAddr     <= shift_reg;
                                havePtr_reg <= 1'b1;
                            end else begin
                                wrData   <= shift_reg;
                                wrStrobe <= 1'b1;
                            end
                        end
                    end
                end
                gpm_pkg::GPM_BS_ACK: begin
                    if (sclFall) begin
                        sdaOe_n <= 1'b1;
                        if (readMode_reg && (ackByte_reg || !sdaSync_reg[1])) begin
                            txByte_reg <= {rdData[6:0], 1'b0};
                            sdaOut     <= 1'b0;
                            sdaOe_n    <= rdData[7];
                            rdStrobe   <= 1'b1;
                            state_reg  <= gpm_pkg::GPM_BS_DATA;
                        end else if (ackByte_reg) begin
                            state_reg <= gpm_pkg::GPM_BS_DATA;
                        end else begin
                            state_reg <= gpm_pkg::GPM_BS_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= gpm_pkg::GPM_BS_IDLE;
                end
            endcase
        end
    end
endmodule

/* tb/gpm_gesture_ctrl_monitor.sv */
// Port checker for LED pulses, sample strobes, interrupt and data pin of the gesture block.
`timescale 1ns/1ns
module gpm_gesture_ctrl_monitor (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sdaOut,
    input wire logic sdaOe_n,
    input wire logic ledDrivePin_n,
    input wire logic sampleUpDown,
    input wire logic sampleLeftRight,
    input wire logic intOe_n,
    input wire logic datasetStored
);
    logic [15:0] lowLen_reg;
    logic [15:0] highLen_reg;
    logic        seenPulse_reg;
    logic        storedEver_reg;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Run lengths of the LED pin; the high count saturates because idle time is unbounded.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lowLen_reg  <= 16'h0000;
            highLen_reg <= 16'h0000;
        end else if (!ledDrivePin_n) begin
            lowLen_reg  <= lowLen_reg + 16'h0001;
            highLen_reg <= 16'h0000;
        end else begin
            lowLen_reg  <= 16'h0000;
            highLen_reg <= (highLen_reg == 16'hFFFF) ? highLen_reg : highLen_reg + 16'h0001;
        end
    end
    // Flags for a first pulse and a first stored dataset since reset.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            seenPulse_reg  <= 1'b0;
            storedEver_reg <= 1'b0;
        end else begin
            seenPulse_reg  <= seenPulse_reg | !ledDrivePin_n;
            storedEver_reg <= storedEver_reg | datasetStored;
        end
    end
    a_pulse_width_set: assert property ($rose(ledDrivePin_n) |-> lowLen_reg == 16'h0190 ||
        lowLen_reg == 16'h0320 || lowLen_reg == 16'h0640 || lowLen_reg == 16'h0C80)
        else $error("Phase_a-time is not one of the four widths");
    a_pulse_min_hold: assert property ($fell(ledDrivePin_n) |=> (!ledDrivePin_n) [*8])
        else $error("LED pulse ended too early");
    a_gap_min_len: assert property ($fell(ledDrivePin_n) && seenPulse_reg |-> highLen_reg >= 16'h0190)
        else $error("LED gap shorter than 400 cycles");
    a_pairs_exclusive: assert property (!(sampleUpDown && sampleLeftRight))
        else $error("both pair samples in one cycle");
    a_sample_one_cycle: assert property (sampleUpDown || sampleLeftRight |=> !sampleUpDown && !sampleLeftRight)
        else $error("sample strobe longer than one cycle");
    a_sample_after_conv: assert property (sampleUpDown || sampleLeftRight |-> ledDrivePin_n && highLen_reg >= 16'h0190)
        else $error("sample before conversion slot ended");
    a_reset_pins_quiet: assert property ($rose(rst_n) |-> ledDrivePin_n && sdaOe_n && intOe_n && !sampleUpDown)
        else $error("pins not idle at reset release");
    a_irq_needs_data: assert property (!intOe_n |-> storedEver_reg)
        else $error("interrupt without any stored dataset");
    a_data_pin_low: assert property (!sdaOe_n |-> !sdaOut)
        else $error("data pin driven high");
endmodule
bind gpm_gesture_ctrl gpm_gesture_ctrl_monitor mon (.core_clk(core_clk), .rst_n(rst_n), .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n), .ledDrivePin_n(ledDrivePin_n), .sampleUpDown(sampleUpDown),
    .sampleLeftRight(sampleLeftRight), .intOe_n(intOe_n), .datasetStored(datasetStored));

/* tb/gpm_host_model.sv */
// Host model: two-wire bus master with an open-drain data line and register tasks.
`timescale 1ns/1ns
`include "gpm_defs.svh"
module gpm_host_model (
    input  wire logic core_clk,
    input  wire logic sdaOut,
    input  wire logic sdaOe_n,
    output logic      sclPin,
    output logic      sdaIn
);
    logic hostLow;
    int   ackMiss;
    // Pulled-up wire: low when either party pulls it, so a released line never shows stale data.
    assign sdaIn = !(hostLow || (!sdaOe_n && !sdaOut));
    initial begin
        sclPin  = 1'b1;
        hostLow = 1'b0;
        ackMiss = 0;
    end
    // Quarter period of the 160 ns link clock.
    task automatic tick();
        repeat (4) @(posedge core_clk);
    endtask
    // Data changes only while the clock is low and is sampled at the end of the high phase.
    task automatic bit_x(input logic b, output logic r);
        hostLow <= !b;
        tick();
        sclPin <= 1'b1;
        tick();
        tick();
        r = sdaIn;
        sclPin <= 1'b0;
        tick();
    endtask
    task automatic start_c();
        hostLow <= 1'b0;
        tick();
        sclPin <= 1'b1;
        tick();
        hostLow <= 1'b1;
        tick();
        sclPin <= 1'b0;
        tick();
    endtask
    task automatic stop_c();
        hostLow <= 1'b1;
        tick();
        sclPin <= 1'b1;
        tick();
        hostLow <= 1'b0;
        tick();
    endtask
    // Sends a byte MSB first and counts an acknowledge that differs from the one wanted.
    task automatic put_byte(input logic [7:0] d, input logic want);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        if (r !== !want) ackMiss++;
    endtask
    task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d);
        start_c();
        put_byte({`GPM_DEV_ADDR, 1'b0}, 1'b1);
        put_byte(ofs, 1'b1);
        put_byte((ofs == `GPM_OFS_AXIS_SELECT) ? (d & 8'h03) : (ofs == `GPM_OFS_CONTROL) ? (d & 8'h07) : d, 1'b1);
        stop_c();
    endtask
    // Single-byte read with a repeated start, closed by a not-acknowledge.
    task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
        logic r;
        start_c();
        put_byte({`GPM_DEV_ADDR, 1'b0}, 1'b1);
        put_byte(ofs, 1'b1);
        start_c();
        put_byte({`GPM_DEV_ADDR, 1'b1}, 1'b1);
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(1'b1, r);
        stop_c();
    endtask
    task automatic probe_addr(input logic [6:0] a);
        start_c();
        put_byte({a, 1'b0}, 1'b0);
        stop_c();
    endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the gesture pulse and mode control block.
`timescale 1ns/1ns
`include "gpm_defs.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("BAD %0t got %0h exp %0h", $time, got, exp); end end
module tb_top;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       sclPin, sdaIn, sdaOut, sdaOe_n, ledDrivePin_n, sampleUpDown, sampleLeftRight, intOut, intOe_n;
    logic       entryThresholdHit = 1'b0;
    logic       exitThresholdHit = 1'b0;
    logic       datasetStored = 1'b0;
    logic       datasetRead = 1'b0;
    logic [7:0] queueFifoThreshold = 8'h00;
    int         fail_count = 0;
    int         check_count = 0;
    int         cyc = 0;
    int         runLen = 0;
    int         udCnt = 0;
    int         lrCnt = 0;
    int         pulseQ[$];
    int         w, c, thr, base;
    always #5 core_clk = ~core_clk;
    gpm_gesture_ctrl uut (.core_clk(core_clk), .rst_n(rst_n), .sclPin(sclPin), .sdaIn(sdaIn), .sdaOut(sdaOut),
        .sdaOe_n(sdaOe_n), .ledDrivePin_n(ledDrivePin_n), .sampleUpDown(sampleUpDown),
        .sampleLeftRight(sampleLeftRight), .intOut(intOut), .intOe_n(intOe_n),
        .entryThresholdHit(entryThresholdHit), .exitThresholdHit(exitThresholdHit), .datasetStored(datasetStored),
        .datasetRead(datasetRead), .queueFifoThreshold(queueFifoThreshold));
    gpm_host_model host (.core_clk(core_clk), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .sclPin(sclPin), .sdaIn(sdaIn));
    // Reference record of Phase_a-times and sample strobes, plus the run-time ceiling.
    always @(posedge core_clk) begin
        cyc++;
        if (!ledDrivePin_n) runLen++;
        else if (runLen > 0) begin
            pulseQ.push_back(runLen);
            runLen = 0;
        end
        udCnt += sampleUpDown;
        lrCnt += sampleLeftRight;
        if (cyc == 90000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic rdchk(input logic [7:0] ofs, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(ofs, d);
        `CHK(d, exp)
    endtask
    // One-cycle dataset strobes, stores or reads, with a quiet cycle between them.
    task automatic strobe(input logic store, input int n);
        repeat (n) begin
            @(posedge core_clk);
            datasetStored <= store;
            datasetRead   <= !store;
            @(posedge core_clk);
            datasetStored <= 1'b0;
            datasetRead   <= 1'b0;
        end
    endtask
    task automatic wait_samples(input int n);
        int b;
        b = udCnt + lrCnt;
        for (int k = 0; k < 20000 && udCnt + lrCnt < b + n; k++) @(posedge core_clk);
        // A wait that runs out counts as a mismatch.
        if (udCnt + lrCnt < b + n) fail_count++;
    endtask
    initial begin
        void'($urandom(20445));
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        rdchk(`GPM_OFS_PULSE_SETUP, 8'h40);
        rdchk(`GPM_OFS_AXIS_SELECT, 8'h00);
        rdchk(`GPM_OFS_CONTROL, 8'h00);
        host.write_reg(8'h10, 8'h5A);
        rdchk(8'h10, 8'h00);
        host.probe_addr(7'h38);
        // Random width and count; the first gesture cycle must hold count plus one pulses of 4 us << width.
        w = $urandom_range(3, 0);
        c = $urandom_range(3, 0);
        host.write_reg(`GPM_OFS_PULSE_SETUP, {w[1:0], c[5:0]});
        rdchk(`GPM_OFS_PULSE_SETUP, {w[1:0], c[5:0]});
        pulseQ.delete();
        host.write_reg(`GPM_OFS_CONTROL, 8'h01);
        wait_samples(1);
        `CHK(pulseQ.size(), c + 1)
        foreach (pulseQ[i]) `CHK(pulseQ[i], (4 * 100) << w)
        rdchk(`GPM_OFS_CONTROL, 8'h01);
        // Every axis code: a single pair is sampled every cycle, both pairs take turns.
        // Only up-down strobes are counted; with the left-right pair alone none may appear.
        host.write_reg(`GPM_OFS_PULSE_SETUP, 8'h00);
        for (int a = 0; a < 4; a++) begin
            host.write_reg(`GPM_OFS_AXIS_SELECT, a[7:0]);
            wait_samples(1);
            base = udCnt;
            wait_samples(2);
            `CHK(udCnt - base, (a == 1) ? 2 : (a == 2) ? 0 : 1)
        end
        // Queue flags, interrupt masking and the flush strobe.
        thr = $urandom_range(2, 0);
        queueFifoThreshold <= thr[7:0];
        host.write_reg(`GPM_OFS_CONTROL, 8'h03);
        strobe(1'b1, thr + 2);
        rdchk(`GPM_OFS_FILL_COUNT, thr[7:0] + 8'h02);
        `CHK(intOe_n, 1'b0)
        `CHK(intOut, 1'b0)
        host.write_reg(`GPM_OFS_CONTROL, 8'h01);
        `CHK(intOe_n, 1'b1)
        host.write_reg(`GPM_OFS_CONTROL, 8'h03);
        `CHK(intOe_n, 1'b0)
        strobe(1'b1, 33);
        rdchk(`GPM_OFS_STATUS, 8'h03);
        host.write_reg(`GPM_OFS_CONTROL, 8'h07);
        rdchk(`GPM_OFS_CONTROL, 8'h03);
        rdchk(`GPM_OFS_FILL_COUNT, 8'h00);
        rdchk(`GPM_OFS_STATUS, 8'h00);
        `CHK(intOe_n, 1'b1)
        // Ready stays while active with an empty queue, and clears only after the mode is left.
        strobe(1'b1, thr + 1);
        strobe(1'b0, thr + 1);
        rdchk(`GPM_OFS_STATUS, 8'h01);
        host.write_reg(`GPM_OFS_CONTROL, 8'h00);
        // Longer than one whole gesture cycle, so the cycle in progress has ended.
        repeat (1000) @(posedge core_clk);
        base = pulseQ.size();
        repeat (3000) @(posedge core_clk);
        `CHK(pulseQ.size(), base)
        rdchk(`GPM_OFS_CONTROL, 8'h00);
        rdchk(`GPM_OFS_STATUS, 8'h00);
        // Threshold events enter and leave the mode just as the mode bit does.
        @(posedge core_clk) entryThresholdHit <= 1'b1;
        @(posedge core_clk) entryThresholdHit <= 1'b0;
        rdchk(`GPM_OFS_CONTROL, 8'h01);
        @(posedge core_clk) exitThresholdHit <= 1'b1;
        @(posedge core_clk) exitThresholdHit <= 1'b0;
        repeat (1000) @(posedge core_clk);
        rdchk(`GPM_OFS_CONTROL, 8'h00);
        `CHK(host.ackMiss, 0)
        tally_and_finish();
    end
endmodule
